// *** verilog/sram_regs.svh ***
`ifndef SRAM_REGS_SVH
`define SRAM_REGS_SVH

`define SRAM_ADDR_W 17
`define SRAM_DATA_W 8
`define SRAM_CNT_W 8

`define SRAM_CLK_PERIOD_NS 4

`define SRAM_T_AA_NS 20
`define SRAM_T_WP_NS 15
`define SRAM_T_HZ_NS 8

`define SRAM_SYNC_STAGES 2

`define SRAM_RD_CYCLES (((`SRAM_T_AA_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS) + `SRAM_SYNC_STAGES)
`define SRAM_WP_CYCLES ((`SRAM_T_WP_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)
`define SRAM_HZ_CYCLES ((`SRAM_T_HZ_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)

`define SRAM_ADDR_RST 17'h00000
`define SRAM_DATA_RST 8'h00
`define SRAM_CNT_ZERO 8'h00
`define SRAM_CNT_ONE 8'h01

`endif

// *** verilog/sram_pkg.sv ***
`include "sram_regs.svh"

package sram_pkg;

  typedef logic [`SRAM_ADDR_W-1:0] addr_t;
  typedef logic [`SRAM_DATA_W-1:0] byte_t;
  typedef logic [`SRAM_CNT_W-1:0]  cnt_t;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_RD_ADDR,
    ST_RD_ACCESS,
    ST_TURN,
    ST_WR_ADDR,
    ST_WR_PULSE,
    ST_WR_HOLD
  } state_e;

endpackage

// *** verilog/sram_timer_if.sv ***
`timescale 1ns/1ps

interface sram_timer_if;
  import sram_pkg::*;

  logic load;
  cnt_t count;
  logic expired;

  modport ctrl
  (
    output load,
    output count,
    input  expired
  );

  modport timer
  (
    input  load,
    input  count,
    output expired
  );

endinterface

// *** verilog/sram_phase_timer.sv ***
`timescale 1ns/1ps
`include "sram_regs.svh"

module sram_phase_timer
(
  input wire logic     clk,
  input wire logic     rst,
  sram_timer_if.timer  tmr
);
  import sram_pkg::*;

  cnt_t cnt_q;
  cnt_t cnt_d;

  // A load of N keeps expired low for N-1 cycles, so a phase lasts exactly N cycles.
  always_comb
  begin
    cnt_d = cnt_q;
    if (tmr.load)
    begin
      cnt_d = tmr.count;
    end
    else if (cnt_q != `SRAM_CNT_ZERO)
    begin
      cnt_d = cnt_q - `SRAM_CNT_ONE;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= `SRAM_CNT_ZERO;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign tmr.expired = (cnt_q == `SRAM_CNT_ONE);

endmodule

// *** verilog/sram_host.sv ***
`timescale 1ns/1ps
`include "sram_regs.svh"

module sram_host
(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           req_valid,
  output logic                req_ready,
  input  wire logic           req_write,
  input  wire sram_pkg::addr_t req_addr,
  input  wire sram_pkg::byte_t req_wdata,
  output logic                rsp_valid,
  output sram_pkg::byte_t     rsp_rdata,
  output sram_pkg::addr_t     word_select_lines,
  output logic                select_low_active_n,
  output logic                select_high_active,
  output logic                write_strobe_n,
  output logic                output_gate_n,
  output sram_pkg::byte_t     byte_lines_o,
  output logic                byte_lines_oe,
  input  wire sram_pkg::byte_t byte_lines_i
);
  import sram_pkg::*;

  sram_timer_if tmr ();

  sram_phase_timer u_timer
  (
    .clk (clk),
    .rst (rst),
    .tmr (tmr.timer)
  );

  byte_t  sync1_q;
  byte_t  sync2_q;
  byte_t  sync1_d;
  byte_t  sync2_d;

  state_e state_q;
  state_e state_d;
  addr_t  addr_q;
  addr_t  addr_d;
  byte_t  wdata_q;
  byte_t  wdata_d;
  byte_t  rdata_q;
  byte_t  rdata_d;
  logic   rsp_q;
  logic   rsp_d;
  logic   sel_q;
  logic   sel_d;
  logic   strobe_q;
  logic   strobe_d;
  logic   gate_q;
  logic   gate_d;
  logic   drive_q;
  logic   drive_d;

  // The byte lines come from a clockless part, so they are sampled through two stages first.
  always_comb
  begin
    sync1_d = byte_lines_i;
    sync2_d = sync1_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= `SRAM_DATA_RST;
      sync2_q <= `SRAM_DATA_RST;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  always_comb
  begin
    state_d   = state_q;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    rdata_d   = rdata_q;
    rsp_d     = 1'b0;
    tmr.load  = 1'b0;
    tmr.count = `SRAM_CNT_ONE;
    case (state_q)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          addr_d  = req_addr;
          wdata_d = req_wdata;
          if (req_write)
          begin
            state_d = ST_WR_ADDR;
          end
          else
          begin
            state_d = ST_RD_ADDR;
          end
        end
      end
      ST_RD_ADDR:
      begin
        // The address has stood a full cycle before the selects turn on.
        state_d   = ST_RD_ACCESS;
        tmr.load  = 1'b1;
        tmr.count = `SRAM_CNT_W'(`SRAM_RD_CYCLES);
      end
      ST_RD_ACCESS:
      begin
        if (tmr.expired)
        begin
          rdata_d   = sync2_q;
          rsp_d     = 1'b1;
          state_d   = ST_TURN;
          tmr.load  = 1'b1;
          tmr.count = `SRAM_CNT_W'(`SRAM_HZ_CYCLES);
        end
      end
      ST_TURN:
      begin
        // Gives the memory time to float its outputs before a write may drive the bus.
        if (tmr.expired)
        begin
          state_d = ST_IDLE;
        end
      end
      ST_WR_ADDR:
      begin
        state_d   = ST_WR_PULSE;
        tmr.load  = 1'b1;
        tmr.count = `SRAM_CNT_W'(`SRAM_WP_CYCLES);
      end
      ST_WR_PULSE:
      begin
        if (tmr.expired)
        begin
          state_d = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD:
      begin
        rsp_d   = 1'b1;
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase

    sel_d    = 1'b0;
    strobe_d = 1'b0;
    gate_d   = 1'b0;
    drive_d  = 1'b0;
    case (state_d)
      ST_RD_ACCESS:
      begin
        sel_d  = 1'b1;
        gate_d = 1'b1;
      end
      ST_WR_ADDR:
      begin
        sel_d   = 1'b1;
        drive_d = 1'b1;
      end
      ST_WR_PULSE:
      begin
        sel_d    = 1'b1;
        strobe_d = 1'b1;
        drive_d  = 1'b1;
      end
      ST_WR_HOLD:
      begin
        sel_d   = 1'b1;
        drive_d = 1'b1;
      end
      default:
      begin
        sel_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q  <= ST_IDLE;
      addr_q   <= `SRAM_ADDR_RST;
      wdata_q  <= `SRAM_DATA_RST;
      rdata_q  <= `SRAM_DATA_RST;
      rsp_q    <= 1'b0;
      sel_q    <= 1'b0;
      strobe_q <= 1'b0;
      gate_q   <= 1'b0;
      drive_q  <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      rdata_q  <= rdata_d;
      rsp_q    <= rsp_d;
      sel_q    <= sel_d;
      strobe_q <= strobe_d;
      gate_q   <= gate_d;
      drive_q  <= drive_d;
    end
  end

  assign req_ready           = (state_q == ST_IDLE);
  assign rsp_valid           = rsp_q;
  assign rsp_rdata           = rdata_q;
  // The logical address goes out unchanged; the part's row scrambling needs no help here.
  assign word_select_lines   = addr_q;
  // Both selects move together, so either one alone would also deselect the part.
  assign select_low_active_n = ~sel_q;
  assign select_high_active  = sel_q;
  assign write_strobe_n      = ~strobe_q;
  assign output_gate_n       = ~gate_q;
  assign byte_lines_o        = wdata_q;
  assign byte_lines_oe       = drive_q;

endmodule

// *** testbench/sram_host_monitor.sv ***
`timescale 1ns/1ps
module sram_host_monitor
  import sram_pkg::*;
(
  input logic  clk,
  input logic  rst,
  input logic  req_valid,
  input logic  req_ready,
  input logic  req_write,
  input logic  rsp_valid,
  input addr_t word_select_lines,
  input logic  select_low_active_n,
  input logic  select_high_active,
  input logic  write_strobe_n,
  input logic  output_gate_n,
  input byte_t byte_lines_o,
  input logic  byte_lines_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic tk;
  assign tk = req_valid && req_ready;
  chk_sel_pair:
    assert property (select_high_active != select_low_active_n) else $error("split");
  chk_wr_sel:
    assert property (!write_strobe_n |-> !select_low_active_n && select_high_active) else $error("wr sel");
  chk_wr_gate:
    assert property (byte_lines_oe |-> output_gate_n) else $error("wr gate");
  chk_rd_strobe:
    assert property (!output_gate_n |-> write_strobe_n) else $error("rd we");
  chk_rd_addr:
    assert property ($fell(select_low_active_n) && !output_gate_n |-> $stable(word_select_lines)) else $error("addr");
  chk_wr_pulse:
    assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n) else $error("pulse");
  chk_wr_end:
    assert property ($rose(write_strobe_n) |-> byte_lines_oe && $stable(byte_lines_o)) else $error("wr end");
  chk_rd_time:
    assert property (tk && !req_write |-> ##9 rsp_valid) else $error("rd time");
  chk_wr_time:
    assert property (tk && req_write |-> ##7 rsp_valid) else $error("wr time");
  cov_rd: cover property (tk && !req_write);
  cov_wr: cover property (tk && req_write);
  cov_b2b: cover property (tk && rsp_valid);
endmodule

bind sram_host sram_host_monitor mon_u (.clk, .rst, .req_valid, .req_ready, .req_write, .rsp_valid,
  .word_select_lines, .select_low_active_n, .select_high_active, .write_strobe_n, .output_gate_n,
  .byte_lines_o, .byte_lines_oe);

// *** testbench/sram_mem_model.sv ***
`timescale 1ns/1ps
module sram_mem_model
  import sram_pkg::*;
(
  input logic   clk,
  input logic   slow,
  input addr_t  a,
  input logic   ce_n,
  input logic   ce,
  input logic   we_n,
  input logic   oe_n,
  input logic   hoe,
  input byte_t  hd,
  output byte_t dq
);
  byte_t m [0:131071];
  byte_t lst = 8'h5a;
  wire sel = !ce_n && ce;
  wire wr = sel && !we_n;
  wire rd = sel && we_n && !oe_n;
  // A slow part shows data late, yet before the host's capture point.
  wire #14 rd_l = rd;
  always @(negedge wr) m[a] = hd;
  always @(posedge clk) if (hoe || rd) lst <= dq;
  // Released lines show the inverse of the last value, never a held copy.
  assign dq = hoe ? hd : (slow ? rd_l : rd) ? m[a] : ~lst;
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import sram_pkg::*;
  logic        clk = 0, rst = 1, req_valid = 0, req_write = 0, slow = 0;
  logic        req_ready, rsp_valid, lo_n, hi, we_n, oe_n, boe;
  addr_t       req_addr = '0, pins;
  byte_t       req_wdata = '0, rsp_rdata, bo, bi;
  logic [15:0] rnd = 16'h004e;
  int          miscompares = 0, total_checks = 0, cyc = 0;
  byte_t       ref_m [addr_t];
  addr_t       q [$];
  always #2 clk = ~clk;
  sram_host dut_u (.clk, .rst, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid,
    .rsp_rdata, .word_select_lines(pins), .select_low_active_n(lo_n), .select_high_active(hi),
    .write_strobe_n(we_n), .output_gate_n(oe_n), .byte_lines_o(bo), .byte_lines_oe(boe), .byte_lines_i(bi));
  sram_mem_model mem_u (.clk, .slow, .a(pins), .ce_n(lo_n), .ce(hi), .we_n, .oe_n, .hoe(boe), .hd(bo), .dq(bi));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task wrap_up;
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input logic [16:0] s, input logic [16:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task op(input logic w, input addr_t a);
    int n;
    rnd = nx(rnd);
    slow = rnd[4];
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = rnd[7:0];
    while (req_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    req_valid = 0;
    if (w)
      ref_m[a] = req_wdata;
    n = 1;
    while (rsp_valid !== 1'b1 && n < 30)
    begin
      @(negedge clk);
      n++;
    end
    check(17'(n), w ? 17'd7 : 17'd9);
    if (!w)
      check(17'(rsp_rdata), 17'(ref_m[a]));
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 24; i++)
    begin
      rnd = nx(rnd);
      q.push_back(i < 2 ? {17{i[0]}} : {rnd[0], rnd});
      op(1, q[i]);
      if (rnd[2])
        op(0, q[i]);
    end
    foreach (q[i])
      op(0, q[i]);
    wrap_up;
  end
  always @(posedge clk)
    if (++cyc == 3000)
    begin
      miscompares++;
      wrap_up;
    end
endmodule
